/* shared/dpsh_map.vh */
// dpsh_map.vh: constants for the dual-port sram host port controller
// assumes a 20 MHz system clock; all counts but the synchroniser depth derive from ns figures
`ifndef DPSH_MAP_VH
`define DPSH_MAP_VH

// =====================================================================
// clock
// =====================================================================
`define DPSH_CLK_PERIOD_NS   50

// =====================================================================
// device timing figures in ns
// =====================================================================
`define DPSH_T_WP_NS         25    // write pulse width
`define DPSH_T_WZ_NS         20    // strobe low to outputs off
`define DPSH_T_DW_NS         15    // data setup to write end
`define DPSH_T_DH_NS         0     // data hold after write
`define DPSH_T_AS_NS         0     // address setup
`define DPSH_T_WR_NS         2     // write recovery
`define DPSH_T_SWRD_NS       5     // flag write to read
`define DPSH_T_AA_NS         35    // access time for reads
`define DPSH_T_HZ_NS         20    // output off after read

// =====================================================================
// derived counts, least times rounded up, at least one cycle
// =====================================================================
`define DPSH_CYC(ns) (((ns) + `DPSH_CLK_PERIOD_NS - 1) / `DPSH_CLK_PERIOD_NS)
`define DPSH_MIN1(c) (((c) < 1) ? 1 : (c))
`define DPSH_WP_CYC   `DPSH_MIN1(`DPSH_CYC(`DPSH_T_WP_NS))
`define DPSH_WZDW_CYC `DPSH_MIN1(`DPSH_CYC(`DPSH_T_WZ_NS + `DPSH_T_DW_NS))
`define DPSH_WZ_CYC   `DPSH_MIN1(`DPSH_CYC(`DPSH_T_WZ_NS))
`define DPSH_DH_CYC   `DPSH_MIN1(`DPSH_CYC(`DPSH_T_DH_NS))
`define DPSH_AS_CYC   `DPSH_MIN1(`DPSH_CYC(`DPSH_T_AS_NS))
`define DPSH_WR_CYC   `DPSH_MIN1(`DPSH_CYC(`DPSH_T_WR_NS))
`define DPSH_SWRD_CYC `DPSH_MIN1(`DPSH_CYC(`DPSH_T_SWRD_NS))
`define DPSH_AA_CYC   `DPSH_MIN1(`DPSH_CYC(`DPSH_T_AA_NS))
`define DPSH_HZ_CYC   `DPSH_MIN1(`DPSH_CYC(`DPSH_T_HZ_NS))
`define DPSH_SYNC_CYC 2     // data pin synchroniser depth

// =====================================================================
// widths and reset values
// =====================================================================
`define DPSH_AW          14
`define DPSH_DW          9
`define DPSH_CW          4
`define DPSH_CNT_ZERO    4'h0
`define DPSH_CNT_ONE     4'h1
`define DPSH_ADDR_ZERO   14'h0000
`define DPSH_DATA_ZERO   9'h000
`define DPSH_FLAG_ADDR_W 3

`endif

/* src/dpsh_host.v */
// dpsh_host.v: host controller for one port of a dual-port static ram
// assumes the device pins are wired directly; data pins are split into
// input, output and enable; the bench resolves the shared wire.
//
// Summary of operation
// - array access drives chip select low with flag select high, flag access the reverse, held all cycle.
// - strobe and chip select are high whenever the address changes.
// - write data is not driven while the device may still drive the data pins.
// - with output enable low the strobe pulse covers turn-off plus data setup, else just the pulse width.
// - chip select stays high across a flag write and the following flag read.
// - a flag read waits the write-to-read interval after a flag write.
// - write data is held at least the hold time after the write ends.
// - both ports use identical sequencing, so this controller serves either port.
`timescale 1ns/1ps
`include "dpsh_map.vh"

module dpsh_host
(
    // clock and reset
    input  wire                     sys_clk_i,
    input  wire                     rst_b_i,
    // user request
    input  wire                     req_valid_i,
    input  wire                     req_write_i,
    input  wire                     req_flag_i,
    input  wire                     req_oe_low_i,
    input  wire [`DPSH_AW-1:0]      req_addr_i,
    input  wire [`DPSH_DW-1:0]      req_wdata_i,
    output wire                     req_ready_o,
    // user answer
    output reg                      rsp_valid_o,
    output reg  [`DPSH_DW-1:0]      rsp_rdata_o,
    // device pins
    output reg                      chip_sel_n_o,
    output reg                      flag_select_n_o,
    output reg                      rw_n_o,
    output reg                      out_en_n_o,
    output reg  [`DPSH_AW-1:0]      addr_o,
    output reg  [`DPSH_DW-1:0]      data_o,
    output reg                      data_oe_o,
    input  wire [`DPSH_DW-1:0]      data_i
);

    // =================================================================
    // states
    // =================================================================
    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_SETUP = 3'd1;
    localparam [2:0] ST_PULSE = 3'd2;
    localparam [2:0] ST_HOLD  = 3'd3;
    localparam [2:0] ST_READ  = 3'd4;
    localparam [2:0] ST_REC   = 3'd5;

    // =================================================================
    // state and datapath registers
    // =================================================================
    reg  [2:0]           state_reg;
    reg  [`DPSH_CW-1:0]  cnt_reg;
    reg                  write_reg;
    reg                  flag_reg;
    reg                  oe_low_reg;
    reg                  flag_wr_gap_reg;
    reg  [`DPSH_CW-1:0]  gap_cnt_reg;
    reg  [`DPSH_DW-1:0]  data_s1_reg;
    reg  [`DPSH_DW-1:0]  data_s2_reg;

    // cycles-to-load helper
    function [`DPSH_CW-1:0] dpsh_len;
        input integer cyc;
        begin
            dpsh_len = cyc[`DPSH_CW-1:0];
        end
    endfunction

    // flag read blocked until the write-to-read gap has passed
    wire gap_block = flag_wr_gap_reg & req_flag_i & ~req_write_i;
    assign req_ready_o = (state_reg == ST_IDLE) & ~gap_block;
    wire take = req_valid_i & req_ready_o;

    // strobe pulse length depends on output enable level
    wire [`DPSH_CW-1:0] pulse_len = oe_low_reg ?
        ((`DPSH_WZDW_CYC > `DPSH_WP_CYC) ? dpsh_len(`DPSH_WZDW_CYC)
                                         : dpsh_len(`DPSH_WP_CYC))
        : dpsh_len(`DPSH_WP_CYC);

    // data pin synchroniser, second stage only is read
    always @(posedge sys_clk_i)
    begin
        data_s1_reg <= data_i;
        data_s2_reg <= data_s1_reg;
    end

    // flag write to read gap tracker
    always @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            flag_wr_gap_reg <= 1'b0;
            gap_cnt_reg     <= `DPSH_CNT_ZERO;
        end
        else if (state_reg == ST_HOLD && flag_reg && cnt_reg == `DPSH_CNT_ONE)
        begin
            flag_wr_gap_reg <= 1'b1;
            gap_cnt_reg     <= dpsh_len(`DPSH_SWRD_CYC);
        end
        else if (flag_wr_gap_reg)
        begin
            if (gap_cnt_reg == `DPSH_CNT_ONE)
                flag_wr_gap_reg <= 1'b0;
            gap_cnt_reg <= gap_cnt_reg - `DPSH_CNT_ONE;
        end
    end

    // main sequencer
    always @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            state_reg       <= ST_IDLE;
            cnt_reg         <= `DPSH_CNT_ZERO;
            write_reg       <= 1'b0;
            flag_reg        <= 1'b0;
            oe_low_reg      <= 1'b0;
            chip_sel_n_o    <= 1'b1;
            flag_select_n_o <= 1'b1;
            rw_n_o          <= 1'b1;
            out_en_n_o      <= 1'b1;
            addr_o          <= `DPSH_ADDR_ZERO;
            data_o          <= `DPSH_DATA_ZERO;
            data_oe_o       <= 1'b0;
            rsp_valid_o     <= 1'b0;
            rsp_rdata_o     <= `DPSH_DATA_ZERO;
        end
        else
        begin
            rsp_valid_o <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    if (take)
                    begin
                        // address moves only while both selects and strobe are high
                        addr_o     <= req_addr_i;
                        data_o     <= req_wdata_i;
                        write_reg  <= req_write_i;
                        flag_reg   <= req_flag_i;
                        oe_low_reg <= req_oe_low_i;
                        cnt_reg    <= dpsh_len(`DPSH_AS_CYC);
                        state_reg  <= ST_SETUP;
                    end
                end
                ST_SETUP:
                begin
                    if (cnt_reg == `DPSH_CNT_ONE)
                    begin
                        // on a write the strobe falls together with the select: outputs stay off
                        rw_n_o          <= ~write_reg;
                        chip_sel_n_o    <= flag_reg;
                        flag_select_n_o <= ~flag_reg;
                        out_en_n_o      <= write_reg ? ~oe_low_reg : 1'b0;
                        if (write_reg)
                        begin
                            // select falls with strobe, so device pins never turn on
                            data_oe_o <= 1'b1;
                            cnt_reg   <= pulse_len;
                            state_reg <= ST_PULSE;
                        end
                        else
                        begin
                            cnt_reg   <= dpsh_len(`DPSH_AA_CYC + `DPSH_SYNC_CYC);
                            state_reg <= ST_READ;
                        end
                    end
                    else
                        cnt_reg <= cnt_reg - `DPSH_CNT_ONE;
                end
                ST_PULSE:
                begin
                    // data stands through the pulse; overlap defines the write
                    if (cnt_reg == `DPSH_CNT_ONE)
                    begin
                        rw_n_o          <= 1'b1;
                        chip_sel_n_o    <= 1'b1;
                        flag_select_n_o <= 1'b1;
                        out_en_n_o      <= 1'b1;
                        cnt_reg         <= dpsh_len(`DPSH_DH_CYC);
                        state_reg       <= ST_HOLD;
                    end
                    else
                        cnt_reg <= cnt_reg - `DPSH_CNT_ONE;
                end
                ST_HOLD:
                begin
                    // data kept after write end for the hold time
                    if (cnt_reg == `DPSH_CNT_ONE)
                    begin
                        data_oe_o   <= 1'b0;
                        rsp_valid_o <= 1'b1;
                        rsp_rdata_o <= data_o;
                        cnt_reg     <= dpsh_len(`DPSH_WR_CYC);
                        state_reg   <= ST_REC;
                    end
                    else
                        cnt_reg <= cnt_reg - `DPSH_CNT_ONE;
                end
                ST_READ:
                begin
                    // capture after access time plus synchroniser delay
                    if (cnt_reg == `DPSH_CNT_ONE)
                    begin
                        rsp_valid_o     <= 1'b1;
                        rsp_rdata_o     <= data_s2_reg;
                        chip_sel_n_o    <= 1'b1;
                        flag_select_n_o <= 1'b1;
                        rw_n_o          <= 1'b1;
                        out_en_n_o      <= 1'b1;
                        cnt_reg         <= dpsh_len(`DPSH_HZ_CYC);
                        state_reg       <= ST_REC;
                    end
                    else
                        cnt_reg <= cnt_reg - `DPSH_CNT_ONE;
                end
                ST_REC:
                begin
                    if (cnt_reg == `DPSH_CNT_ONE)
                        state_reg <= ST_IDLE;
                    else
                        cnt_reg <= cnt_reg - `DPSH_CNT_ONE;
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

endmodule

/* bench/dpsh_host_monitor.sv */
// dpsh_host_monitor.sv: pin sequencing checks for the sram host port
// assumes binding to dpsh_host; sees only that module's ports
`timescale 1ns/1ps
`include "dpsh_map.vh"
module dpsh_host_monitor
(
    // clock, reset and handshake
    input wire                sys_clk_i,
    input wire                rst_b_i,
    input wire                req_valid_i,
    input wire                req_write_i,
    input wire                req_ready_o,
    input wire                rsp_valid_o,
    // device pins
    input wire                chip_sel_n_o,
    input wire                flag_select_n_o,
    input wire                rw_n_o,
    input wire                out_en_n_o,
    input wire [`DPSH_AW-1:0] addr_o,
    input wire [`DPSH_DW-1:0] data_o,
    input wire                data_oe_o
);
// ==================================================================
// assertions
default clocking dpsh_cb @(posedge sys_clk_i); endclocking
default disable iff (!rst_b_i);
sel_excl_a: assert property (chip_sel_n_o || flag_select_n_o)
    else $error("both selects low");
sel_stable_a: assert property (!rw_n_o |-> (chip_sel_n_o ^ flag_select_n_o) ##1
    (rw_n_o && chip_sel_n_o && flag_select_n_o)) else $error("select moved in write");
addr_quiet_a: assert property (!$stable(addr_o) |-> (rw_n_o || chip_sel_n_o) &&
    ($past(rw_n_o) || $past(chip_sel_n_o))) else $error("address moved in write");
drive_late_a: assert property ($rose(data_oe_o) |->
    $past(out_en_n_o) || !$past(rw_n_o) || ($past(chip_sel_n_o) && $past(flag_select_n_o)))
    else $error("data driven too early");
pulse_one_a: assert property ($fell(rw_n_o) |->
    (chip_sel_n_o ^ flag_select_n_o) ##1 rw_n_o) else $error("write pulse wrong");
flag_gap_a: assert property ($fell(flag_select_n_o) && rw_n_o |->
    $past(rw_n_o) && $past(rw_n_o, 2)) else $error("flag read too soon");
data_hold_a: assert property ($rose(rw_n_o) |->
    $past(data_oe_o) && data_oe_o && $stable(data_o)) else $error("write data not held");
answer_wr_a: assert property (req_valid_i && req_ready_o && req_write_i |-> ##4 rsp_valid_o)
    else $error("write answer not after four cycles");
answer_rd_a: assert property (req_valid_i && req_ready_o && !req_write_i |-> ##5 rsp_valid_o)
    else $error("read answer not after five cycles");
busy_a: assert property (req_valid_i && req_ready_o |=> !req_ready_o [*3])
    else $error("ready while busy");
endmodule
bind dpsh_host dpsh_host_monitor mon (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .req_valid_i(req_valid_i), .req_write_i(req_write_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .chip_sel_n_o(chip_sel_n_o), .flag_select_n_o(flag_select_n_o), .rw_n_o(rw_n_o),
    .out_en_n_o(out_en_n_o), .addr_o(addr_o), .data_o(data_o), .data_oe_o(data_oe_o));

/* bench/dpsh_dev_model.sv */
// dpsh_dev_model.sv: behavioural model of one dual-port sram port
// assumes the bench resolves the shared data wire; no clock, no reset
`timescale 1ns/1ps
module dpsh_dev_model
(
    // control pins, active low
    input  wire        chip_sel_n_i,
    input  wire        flag_select_n_i,
    input  wire        rw_n_i,
    input  wire        out_en_n_i,
    // address and data
    input  wire [13:0] addr_i,
    input  wire [8:0]  bus_i,
    output wire [8:0]  dq_o,
    output wire        dq_oe_o
);
// ==================================================================
// storage
reg [8:0] mem [0:16383];
reg [7:0] flag;
initial flag = 8'hff;
// store only during the low overlap of select and strobe
always @*
begin
    if (!chip_sel_n_i && flag_select_n_i && !rw_n_i) mem[addr_i] = bus_i;
    if (chip_sel_n_i && !flag_select_n_i && !rw_n_i) flag[addr_i[2:0]] = bus_i[0];
end
// drive only a selected read; strobe low keeps pins off
assign dq_oe_o = rw_n_i && !out_en_n_i && (chip_sel_n_i ^ flag_select_n_i);
assign dq_o    = chip_sel_n_i ? {9{flag[addr_i[2:0]]}} : mem[addr_i];
endmodule

/* bench/tb.sv */
// tb.sv: self-checking bench for the sram host port controller
// assumes a device model on the pins and a resolved data wire
`timescale 1ns/1ps
module tb;
reg sys_clk_i = 1'b0, rst_b_i = 1'b0, req_valid_i = 1'b0, req_write_i = 1'b0;
reg req_flag_i = 1'b0, req_oe_low_i = 1'b0;
reg [13:0] req_addr_i = 14'h0000;
reg [8:0] req_wdata_i = 9'h000, last_bus = 9'h000, q;
wire req_ready_o, rsp_valid_o, cs_n, flag_sel_n, rw_n, oe_n, data_oe, dq_oe;
wire [8:0] rsp_rdata_o, data_o, dq, data_i;
wire [13:0] addr;
integer fail_count = 0, compares = 0, cyc = 0, i;
// ==================================================================
// clock, wire resolution, timeout
always #25 sys_clk_i = ~sys_clk_i;
assign data_i = data_oe ? data_o : dq_oe ? dq : ~last_bus;
always @(posedge sys_clk_i)
begin
    last_bus <= data_i;
    cyc = cyc + 1;
    if (data_oe && dq_oe) chk("bus fight", 9'h000, 9'h001);
    if (cyc > 4000) begin fail_count = fail_count + 1; wrap_up; end
end
dpsh_host uut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_flag_i(req_flag_i), .req_oe_low_i(req_oe_low_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .chip_sel_n_o(cs_n),
    .flag_select_n_o(flag_sel_n), .rw_n_o(rw_n), .out_en_n_o(oe_n), .addr_o(addr),
    .data_o(data_o), .data_oe_o(data_oe), .data_i(data_i));
dpsh_dev_model dev (.chip_sel_n_i(cs_n), .flag_select_n_i(flag_sel_n), .rw_n_i(rw_n),
    .out_en_n_i(oe_n), .addr_i(addr), .bus_i(data_i), .dq_o(dq), .dq_oe_o(dq_oe));
task chk(input string name, input [8:0] exp, input [8:0] got);
begin
    compares = compares + 1;
    if (got !== exp)
    begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
end
endtask
// one request, held until taken, then wait for the answer
task xfer(input w, input f, input o, input [13:0] a, input [8:0] d);
    integer n;
begin
    @(posedge sys_clk_i);
    req_valid_i <= 1'b1; req_write_i <= w; req_flag_i <= f;
    req_oe_low_i <= o; req_addr_i <= a; req_wdata_i <= d;
    n = 0;
    @(negedge sys_clk_i);
    while (req_ready_o !== 1'b1 && n < 20) begin @(negedge sys_clk_i); n = n + 1; end
    @(posedge sys_clk_i);
    req_valid_i <= 1'b0;
    n = 0;
    do begin @(negedge sys_clk_i); n = n + 1; end while (rsp_valid_o !== 1'b1 && n < 20);
    chk("latency", w ? 9'h004 : 9'h005, n[8:0]);
    q = rsp_rdata_o;
end
endtask
task t_reset;
begin
    chk("idle pins", 9'h03d, {3'b000, cs_n, flag_sel_n, rw_n, oe_n, data_oe, req_ready_o});
    $display("test reset done");
end
endtask
task t_array;
    reg [13:0] a [0:3];
begin
    a[0] = 14'h0000; a[1] = 14'h3fff; a[2] = 14'h1555; a[3] = 14'h2aaa;
    for (i = 0; i < 4; i = i + 1)
    begin
        xfer(1'b1, 1'b0, i[0], a[i], 9'h0a5 + i[8:0]);
        chk("write echo", 9'h0a5 + i[8:0], q);
    end
    for (i = 0; i < 4; i = i + 1)
    begin
        xfer(1'b0, 1'b0, 1'b0, a[i], 9'h000);
        chk("array read", 9'h0a5 + i[8:0], q);
    end
    $display("test array done");
end
endtask
task t_flag;
begin
    for (i = 0; i < 8; i = i + 1)
    begin
        xfer(1'b1, 1'b1, 1'b0, i[13:0], {8'h00, i[0]});
        xfer(1'b0, 1'b1, 1'b0, i[13:0], 9'h000);
        chk("flag read", {9{i[0]}}, q);
    end
    xfer(1'b0, 1'b0, 1'b0, 14'h0000, 9'h000);
    chk("array untouched", 9'h0a5, q);
    $display("test flag done");
end
endtask
task wrap_up;
begin
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
end
endtask
initial
begin
    repeat (8) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    @(negedge sys_clk_i);
    t_reset;
    t_array;
    t_flag;
    wrap_up;
end
endmodule
